// file: serial_mode_cfg.svh
// Behaviour
// RULE1: transfer_mode 00 I/O interface, 01 7-bit, 10 8-bit, 11 9-bit UART.
// RULE2: uart_clock_select picks timer, baud generator, system clock or pin clock.
// RULE3: 9-bit UART sends tx_ninth_bit as the ninth data bit.
// RULE4: handshake_enable gates transmit start by CTS; otherwise CTS ignored.
// RULE5: software keeps receive enable low while programming the mode registers.
// RULE6: 9-bit UART with wakeup_filter raises receive event only for ninth bit 1.
// RULE7: duplex_select sets direction in I/O mode; UART ignores it for direction.
// RULE8: transmit enable gates transmission; a running frame always completes.
// RULE9: software sets transfer mode before transmit enable.
// RULE10: I/O internal clock with buffering inserts 0..64 clock gap between frames.
// RULE11: idle_keep_running keeps the channel running in IDLE, else it stops.
// RULE12: tx_fifo_control reinitialised when channel disabled or stopped by IDLE.
// RULE13: tx buffer empty resets 1, sets on move to shifter, clears on write.
// RULE14: rx_buffer_full sets when frame enters receive buffer, clears on read.
// RULE15: transmitting and buffer-empty flags combine into progress/complete/waiting.
// RULE16: UART sends one or two stop bits; receiver checks one only.
// RULE17: bit_order picks LSB/MSB first in I/O mode; UART is LSB first.
// RULE18: double buffer enable governs transmit; receive is always double buffered. Code uses dbuf_en only to gate the RULE10 gap.
// RULE19: writing 10 then 01 to soft_reset_field resets channel flags and enables.
// RULE20: soft reset executes two clocks after the sequence is recognised.
// RULE21: during transmission software issues the reset sequence twice.
// RULE22: after soft reset software reprograms mode and control registers.
// RULE23: channel_operation_enable low freezes channel state except tx_fifo_control.
`ifndef SERIAL_MODE_CFG_SVH
`define SERIAL_MODE_CFG_SVH
`define OFS_MODE0    8'h00
`define OFS_MODE1    8'h04
`define OFS_MODE2    8'h08
`define OFS_ENABLE   8'h0C
`define OFS_DATA     8'h10
`define OFS_ERROR    8'h14
`define RST_MODE0    8'h00
`define RST_MODE1    8'h00
`define RST_CFG2     3'h0
`define SRST_ARM     2'h2
`define SRST_FIRE    2'h1
`define SRST_DELAY   2'h2
`define MODE_IO      2'h0
`define MODE_U9      2'h3
`define CLK_TIMER    2'h0
`define CLK_BAUD     2'h1
`define CLK_SYS      2'h2
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

// file: serial_mode_ctrl.sv
`timescale 1ns/1ns
`include "serial_mode_cfg.svh"
module serial_mode_ctrl (
	// clock, reset, enable
	input  wire logic        REF_CLK,
	input  wire logic        RST_N,
	input  wire logic        CLK_EN,
	// axi4-lite write
	input  wire logic [7:0]  AWADDR,
	input  wire logic        AWVALID,
	output logic             AWREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output logic             WREADY,
	output logic [1:0]       BRESP,
	output logic             BVALID,
	input  wire logic        BREADY,
	// axi4-lite read
	input  wire logic [7:0]  ARADDR,
	input  wire logic        ARVALID,
	output logic             ARREADY,
	output logic [31:0]      RDATA,
	output logic [1:0]       RRESP,
	output logic             RVALID,
	input  wire logic        RREADY,
	// clock sources
	input  wire logic        TIMER_OUT,
	input  wire logic        BAUD_TICK,
	input  wire logic        SERIAL_CLOCK_PIN,
	// serial pins and system state
	input  wire logic        RXD,
	input  wire logic        CTS_N,
	input  wire logic        IDLE_MODE,
	output logic             TXD,
	output logic             RX_EVENT,
	output logic             TX_FIFO_INIT
);
	// ==================================================
	// helpers
	function automatic logic [7:0] rev8(input logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			rev8[i] = d[7 - i];
		end
	endfunction : rev8

	// RULE1 mode widths
	function automatic logic [3:0] data_bits(input logic [1:0] m);
		data_bits = (m == `MODE_IO) ? 4'd8 : {2'b00, m} + 4'd6;
	endfunction : data_bits

	// ==================================================
	// registers
	logic [7:0]  mode0_reg, mode1_reg;
	logic [2:0]  cfg2_reg;
	logic        chan_en_reg;
	logic        tx_empty_reg, rx_full_reg, tx_run_reg;
	logic [7:0]  tx_hold_reg, rx_data_reg;
	logic        rx_ninth_reg, ovr_reg, frm_reg;
	logic        sr_armed_reg;
	logic [1:0]  sr_cnt_reg;
	logic [2:0]  sclk_sync_reg, rxd_sync_reg, cts_sync_reg;
	logic        timer_d_reg;
	logic [7:0]  aw_addr_reg, ar_addr_reg;
	logic [31:0] w_data_reg;
	logic        aw_held_reg, w_held_reg;
	serial_mode_pkg::tx_state_e tx_state_reg;
	serial_mode_pkg::rx_state_e rx_state_reg;
	logic [11:0] tx_shift_reg;
	logic [3:0]  tx_cnt_reg, rx_cnt_reg;
	logic [6:0]  gap_cnt_reg;
	logic [8:0]  rx_shift_reg;

	// ==================================================
	// field decode
	wire       tx_ninth_bit     = mode0_reg[7];
	wire       handshake_enable = mode0_reg[6];
	wire       rx_en            = mode0_reg[5];
	wire       wakeup_filter    = mode0_reg[4];
	wire [1:0] transfer_mode    = mode0_reg[3:2];
	wire [1:0] uart_clock_select = mode0_reg[1:0];
	wire       idle_keep_running = mode1_reg[7];
	wire [1:0] duplex_select    = mode1_reg[6:5];
	wire       tx_en            = mode1_reg[4];
	wire [2:0] frame_gap_select = mode1_reg[3:1];
	wire       stop_length      = cfg2_reg[2];
	wire       bit_order        = cfg2_reg[1];
	wire       dbuf_en          = cfg2_reg[0];
	wire       io_mode          = (transfer_mode == `MODE_IO);

	// ==================================================
	// run gate: disable or unrequested idle freezes the engines
	// RULE11 idle stop, RULE23 disable freeze
	wire run = chan_en_reg & ~(IDLE_MODE & ~idle_keep_running);

	// the pin clock is edge-detected from its synchronised copy; the timer edge uses raw TIMER_OUT
	wire sclk_rise  = sclk_sync_reg[1] & ~sclk_sync_reg[2];
	wire timer_rise = TIMER_OUT & ~timer_d_reg;
	wire rxd_s      = rxd_sync_reg[1];
	wire cts_ok     = ~cts_sync_reg[1];

	// RULE2 clock source
	wire uart_tick = (uart_clock_select == `CLK_TIMER) ? timer_rise :
		(uart_clock_select == `CLK_BAUD) ? BAUD_TICK :
		(uart_clock_select == `CLK_SYS) ? 1'b1 : sclk_rise;
	wire tick = run & (io_mode ? BAUD_TICK : uart_tick);

	// ==================================================
	// bus handshake decode
	logic w_strb0;
	logic [3:0] w_strb_reg;
	assign w_strb0 = w_strb_reg[0];
	wire wr_go = aw_held_reg & w_held_reg & ~BVALID;
	wire rd_go = ARVALID & ARREADY;
	wire wr_m0 = wr_go & (aw_addr_reg == `OFS_MODE0) & w_strb0;
	wire wr_m1 = wr_go & (aw_addr_reg == `OFS_MODE1) & w_strb0;
	wire wr_m2 = wr_go & (aw_addr_reg == `OFS_MODE2) & w_strb0;
	wire wr_en = wr_go & (aw_addr_reg == `OFS_ENABLE) & w_strb0;
	wire wr_dt = wr_go & (aw_addr_reg == `OFS_DATA) & w_strb0;
	wire wr_hit = (aw_addr_reg[7:5] == 3'h0) & (aw_addr_reg[4:0] <= 5'h14)
		& (aw_addr_reg[1:0] == 2'b00);
	wire rd_hit = (ARADDR[7:5] == 3'h0) & (ARADDR[4:0] <= 5'h14)
		& (ARADDR[1:0] == 2'b00);
	wire rd_m2 = rd_go & (ARADDR == `OFS_MODE2);
	wire rd_dt = rd_go & (ARADDR == `OFS_DATA);
	wire rd_er = rd_go & (ARADDR == `OFS_ERROR);

	// RULE19 reset sequence recognised
	wire sr_hit  = wr_m2 & (w_data_reg[1:0] == `SRST_FIRE) & sr_armed_reg;
	// RULE20 executes at count one
	wire sr_exec = (sr_cnt_reg == 2'd1);

	wire [31:0] rd_mux =
		(ARADDR == `OFS_MODE0) ? {24'h0, mode0_reg} :
		(ARADDR == `OFS_MODE1) ? {24'h0, mode1_reg[7:1], 1'b0} :
		// RULE15 combined status
		(ARADDR == `OFS_MODE2) ? {24'h0, tx_empty_reg, rx_full_reg,
			tx_run_reg, cfg2_reg, 2'b00} :
		(ARADDR == `OFS_ENABLE) ? {31'h0, chan_en_reg} :
		(ARADDR == `OFS_DATA) ? {23'h0, rx_ninth_reg, rx_data_reg} :
		{29'h0, ovr_reg, 1'b0, frm_reg};

	// ==================================================
	// transmit frame build
	// RULE3 ninth bit, RULE17 order
	wire [7:0]  tx_io_data = bit_order ? rev8(tx_hold_reg) : tx_hold_reg;
	wire [11:0] tx_frame =
		io_mode ? {4'hF, tx_io_data} :
		(transfer_mode == `MODE_U9) ? {2'b11, tx_ninth_bit, tx_hold_reg, 1'b0} :
		(transfer_mode == 2'h2) ? {3'b111, tx_hold_reg, 1'b0} :
		{4'hF, tx_hold_reg[6:0], 1'b0};
	// RULE16 stop length
	wire [3:0] tx_len = io_mode ? 4'd8 :
		data_bits(transfer_mode) + 4'd2 + {3'h0, stop_length};
	// RULE7 direction, RULE8 gate, RULE4 handshake
	wire tx_dir_ok = ~io_mode | duplex_select[1];
	wire tx_start  = ~tx_empty_reg & tx_en & tx_dir_ok
		& (~handshake_enable | cts_ok);
	// RULE10 gap only with internal clock and buffering
	wire [6:0] gap_len = (frame_gap_select == 3'h0) ? 7'h00 :
		7'(7'h01 << (frame_gap_select - 3'h1));
	wire gap_on = io_mode & dbuf_en & (gap_len != 7'h00);

	// ==================================================
	// receive decode
	wire [3:0] rx_nb    = data_bits(transfer_mode);
	// i/o frames end on the last data tick, so that bit is folded in here
	wire [8:0] rx_src   = io_mode ? {rxd_s, rx_shift_reg[8:1]} : rx_shift_reg;
	wire [8:0] rx_align = 9'(rx_src >> (4'd9 - rx_nb));
	wire [7:0] rx_word  = (io_mode & bit_order) ? rev8(rx_align[7:0])
		: rx_align[7:0];
	wire rx_ninth = (transfer_mode == `MODE_U9) & rx_align[8];
	wire rx_dir_ok = ~io_mode | duplex_select[0];
	wire rx_done = tick & rx_en & rx_dir_ok & ((rx_state_reg == serial_mode_pkg::RX_STOP) |
		(io_mode & rx_state_reg == serial_mode_pkg::RX_DATA
		& rx_cnt_reg == 4'd1));
	// RULE6 wakeup filtering
	wire rx_notify = ~((transfer_mode == `MODE_U9) & wakeup_filter) | rx_ninth;

	// ==================================================
	// synchronisers and axi channels
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			sclk_sync_reg <= 3'h0;
			rxd_sync_reg  <= 3'h7;
			cts_sync_reg  <= 3'h7;
			timer_d_reg   <= 1'b0;
		end else if (CLK_EN) begin
			sclk_sync_reg <= {sclk_sync_reg[1:0], SERIAL_CLOCK_PIN};
			rxd_sync_reg  <= {rxd_sync_reg[1:0], RXD};
			cts_sync_reg  <= {cts_sync_reg[1:0], CTS_N};
			timer_d_reg   <= TIMER_OUT;
		end
	end

	// address and data taken in either order, answered together
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg  <= 32'h0;
			w_strb_reg  <= 4'h0;
			AWREADY <= 1'b1;
			WREADY  <= 1'b1;
			BVALID  <= 1'b0;
			BRESP   <= `RESP_OKAY;
		end else if (CLK_EN) begin
			if (AWVALID & AWREADY) begin
				aw_addr_reg <= AWADDR;
				aw_held_reg <= 1'b1;
				AWREADY     <= 1'b0;
			end
			if (WVALID & WREADY) begin
				w_data_reg <= WDATA;
				w_strb_reg <= WSTRB;
				w_held_reg <= 1'b1;
				WREADY     <= 1'b0;
			end
			if (wr_go) begin
				BVALID      <= 1'b1;
				BRESP       <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
			end else if (BVALID & BREADY) begin
				BVALID  <= 1'b0;
				AWREADY <= 1'b1;
				WREADY  <= 1'b1;
			end
		end
	end

	// read answered the cycle after the address is taken
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			ARREADY <= 1'b1;
			RVALID  <= 1'b0;
			RDATA   <= 32'h0;
			RRESP   <= `RESP_OKAY;
		end else if (CLK_EN) begin
			if (rd_go) begin
				ARREADY <= 1'b0;
				RVALID  <= 1'b1;
				RDATA   <= rd_hit ? rd_mux : 32'h0;
				RRESP   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (RVALID & RREADY) begin
				RVALID  <= 1'b0;
				ARREADY <= 1'b1;
			end
		end
	end

	// ==================================================
	// mode registers and soft reset sequencer
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			mode0_reg    <= `RST_MODE0;
			mode1_reg    <= `RST_MODE1;
			cfg2_reg     <= `RST_CFG2;
			chan_en_reg  <= 1'b0;
			sr_armed_reg <= 1'b0;
			sr_cnt_reg   <= 2'h0;
		end else if (CLK_EN) begin
			if (wr_m0) mode0_reg <= w_data_reg[7:0];
			if (wr_m1) mode1_reg <= {w_data_reg[7:1], 1'b0};
			if (wr_m2) cfg2_reg <= w_data_reg[4:2];
			if (wr_en) chan_en_reg <= w_data_reg[0];
			if (wr_m2) sr_armed_reg <= (w_data_reg[1:0] == `SRST_ARM);
			if (sr_hit) sr_cnt_reg <= `SRST_DELAY;
			else if (sr_cnt_reg != 2'h0) sr_cnt_reg <= sr_cnt_reg - 2'h1;
			// RULE19 clears both enables
			if (sr_exec) begin
				mode0_reg[5] <= 1'b0;
				mode1_reg[4] <= 1'b0;
			end
		end
	end

	// ==================================================
	// transmit engine, frozen while not running
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			tx_state_reg <= serial_mode_pkg::TX_IDLE;
			tx_shift_reg <= 12'hFFF;
			tx_cnt_reg   <= 4'h0;
			gap_cnt_reg  <= 7'h00;
			tx_hold_reg  <= 8'h00;
			tx_empty_reg <= 1'b1;
			tx_run_reg   <= 1'b0;
			TXD          <= 1'b1;
		end else if (CLK_EN) begin
			// RULE13 write clears empty
			if (wr_dt) begin
				tx_hold_reg  <= w_data_reg[7:0];
				tx_empty_reg <= 1'b0;
			end
			if (sr_exec) begin
				tx_state_reg <= serial_mode_pkg::TX_IDLE;
				tx_empty_reg <= 1'b1;
				tx_run_reg   <= 1'b0;
				TXD          <= 1'b1;
			end else if (run) begin
				case (tx_state_reg)
					serial_mode_pkg::TX_IDLE: begin
						// RULE13 move to shifter sets empty
						if (tx_start & ~wr_dt) begin
							tx_shift_reg <= tx_frame;
							tx_cnt_reg   <= tx_len;
							tx_empty_reg <= 1'b1;
							tx_run_reg   <= 1'b1;
							tx_state_reg <= serial_mode_pkg::TX_SHIFT;
						end
					end
					serial_mode_pkg::TX_SHIFT: begin
						// RULE8 frame runs to its end
						if (tick) begin
							if (tx_cnt_reg == 4'h0) begin
								TXD          <= 1'b1;
								tx_run_reg   <= 1'b0;
								gap_cnt_reg  <= gap_len;
								tx_state_reg <= gap_on ? serial_mode_pkg::TX_GAP
									: serial_mode_pkg::TX_IDLE;
							end else begin
								TXD          <= tx_shift_reg[0];
								tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
								tx_cnt_reg   <= tx_cnt_reg - 4'h1;
							end
						end
					end
					serial_mode_pkg::TX_GAP: begin
						// RULE10 gap counted in serial clocks
						if (tick) begin
							gap_cnt_reg <= gap_cnt_reg - 7'h01;
							if (gap_cnt_reg == 7'h01) tx_state_reg <= serial_mode_pkg::TX_IDLE;
						end
					end
					default: tx_state_reg <= serial_mode_pkg::TX_IDLE;
				endcase
			end
		end
	end

	// ==================================================
	// receive engine, one sample per serial clock
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			rx_state_reg <= serial_mode_pkg::RX_IDLE;
			rx_shift_reg <= 9'h000;
			rx_cnt_reg   <= 4'h0;
			rx_data_reg  <= 8'h00;
			rx_ninth_reg <= 1'b0;
			rx_full_reg  <= 1'b0;
			ovr_reg      <= 1'b0;
			frm_reg      <= 1'b0;
			RX_EVENT     <= 1'b0;
		end else if (CLK_EN) begin
			RX_EVENT <= 1'b0;
			// RULE14 read clears, later set wins
			if (rd_m2) rx_full_reg <= 1'b0;
			if (rd_er) begin
				ovr_reg <= 1'b0;
				frm_reg <= 1'b0;
			end
			if (sr_exec) begin
				rx_state_reg <= serial_mode_pkg::RX_IDLE;
				rx_full_reg  <= 1'b0;
				ovr_reg      <= 1'b0;
				frm_reg      <= 1'b0;
			end else if (tick & rx_en & rx_dir_ok) begin
				case (rx_state_reg)
					serial_mode_pkg::RX_IDLE: begin
						if (io_mode | ~rxd_s) begin
							rx_cnt_reg   <= rx_nb;
							rx_state_reg <= serial_mode_pkg::RX_DATA;
						end
						if (io_mode) rx_shift_reg <= {rxd_s, 8'h00};
						if (io_mode) rx_cnt_reg <= rx_nb - 4'h1;
					end
					serial_mode_pkg::RX_DATA: begin
						rx_shift_reg <= {rxd_s, rx_shift_reg[8:1]};
						rx_cnt_reg   <= rx_cnt_reg - 4'h1;
						if (rx_cnt_reg == 4'h1) begin
							rx_state_reg <= io_mode ? serial_mode_pkg::RX_IDLE
								: serial_mode_pkg::RX_STOP;
						end
					end
					serial_mode_pkg::RX_STOP: begin
						// RULE16 single stop checked
						if (~rxd_s) frm_reg <= 1'b1; // set beats a clearing read
						rx_state_reg <= serial_mode_pkg::RX_IDLE;
					end
					default: rx_state_reg <= serial_mode_pkg::RX_IDLE;
				endcase
				// RULE18 receive always buffered
				if (rx_done) begin
					rx_data_reg  <= rx_word;
					rx_ninth_reg <= rx_ninth;
					rx_full_reg  <= 1'b1;
					if (rx_full_reg) ovr_reg <= 1'b1;
					RX_EVENT     <= rx_notify;
				end
			end
		end
	end

	// ==================================================
	// RULE12 fifo control reinit while stopped
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) TX_FIFO_INIT <= 1'b1;
		else if (CLK_EN) TX_FIFO_INIT <= ~run;
	end

	// ==================================================
	// checks
	property p_sr_delay;
		@(posedge REF_CLK) disable iff (!RST_N)
		(CLK_EN & sr_hit) ##1 CLK_EN ##1 CLK_EN |=> !mode0_reg[5] & !mode1_reg[4] & tx_empty_reg;
	endproperty
	a_sr_delay: assert property (p_sr_delay) else $error("soft reset not applied"); // RULE20
	property p_no_early_sr;
		@(posedge REF_CLK) disable iff (!RST_N) (CLK_EN & sr_hit) |=> sr_cnt_reg == 2'd2;
	endproperty
	a_no_early_sr: assert property (p_no_early_sr) else $error("reset count wrong"); // RULE19
	property p_cts_gate;
		@(posedge REF_CLK) disable iff (!RST_N)
		(CLK_EN & run & tx_state_reg == serial_mode_pkg::TX_IDLE & handshake_enable & cts_sync_reg[1])
		|=> tx_state_reg == serial_mode_pkg::TX_IDLE;
	endproperty
	a_cts_gate: assert property (p_cts_gate) else $error("sent while cts high"); // RULE4
	property p_txen_gate;
		@(posedge REF_CLK) disable iff (!RST_N)
		(CLK_EN & tx_state_reg == serial_mode_pkg::TX_IDLE & !tx_en) |=> !tx_run_reg;
	endproperty
	a_txen_gate: assert property (p_txen_gate) else $error("sent while disabled"); // RULE8
	property p_empty_set;
		@(posedge REF_CLK) disable iff (!RST_N)
		(CLK_EN & !tx_run_reg & $rose(tx_run_reg) == 0 ##1 $rose(tx_run_reg)) |-> tx_empty_reg | $past(wr_dt);
	endproperty
	a_empty_set: assert property (p_empty_set) else $error("empty not set on load"); // RULE13
	property p_full_set;
		@(posedge REF_CLK) disable iff (!RST_N) (CLK_EN & rx_done & !sr_exec) |=> rx_full_reg;
	endproperty
	a_full_set: assert property (p_full_set) else $error("full not set"); // RULE14
	property p_wakeup;
		@(posedge REF_CLK) disable iff (!RST_N)
		(CLK_EN & rx_done & transfer_mode == `MODE_U9 & wakeup_filter & !rx_ninth) |=> !RX_EVENT;
	endproperty
	a_wakeup: assert property (p_wakeup) else $error("wakeup filter failed"); // RULE6
	property p_fifo_init;
		@(posedge REF_CLK) disable iff (!RST_N) (CLK_EN & !chan_en_reg) |=> TX_FIFO_INIT;
	endproperty
	a_fifo_init: assert property (p_fifo_init) else $error("fifo init missing"); // RULE12
	property p_freeze;
		@(posedge REF_CLK) disable iff (!RST_N)
		(CLK_EN & !run & !sr_exec & !wr_dt) |=> $stable(tx_state_reg) & $stable(TXD);
	endproperty
	a_freeze: assert property (p_freeze) else $error("engine ran while stopped"); // RULE23
	c_frame: cover property (@(posedge REF_CLK) $fell(tx_run_reg));
	c_rx: cover property (@(posedge REF_CLK) RX_EVENT);
	c_sr: cover property (@(posedge REF_CLK) sr_exec);
endmodule : serial_mode_ctrl

// file: serial_mode_pkg.sv
package serial_mode_pkg;
	typedef enum logic [1:0] {
		TX_IDLE  = 2'b00,
		TX_SHIFT = 2'b01,
		TX_GAP   = 2'b10
	} tx_state_e;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_DATA = 2'b01,
		RX_STOP = 2'b10
	} rx_state_e;
endpackage : serial_mode_pkg

// file: serial_peer.sv
`timescale 1ns/1ns
// ==================================================
// serial peer on the far side of the channel pins
module serial_peer #(
	parameter int BIT_CLKS = 8
) (
	// clock and bit tick
	input  wire logic ref_clk,
	input  wire logic baud_tick,
	// serial pins
	input  wire logic txd,
	output logic      rxd,
	output logic      cts_n,
	output logic      serial_clock_pin
);
	// line driven high at idle; pin clock stands still
	initial begin
		rxd = 1'h1;
		cts_n = 1'h1;
		serial_clock_pin = 1'h0;
	end
	task automatic set_cts(input logic v);
		@(posedge ref_clk);
		cts_n <= v;
	endtask : set_cts
	task automatic send_frame(input logic [8:0] d);
		logic [10:0] f;
		f = {1'h1, d, 1'h0};
		// bits change right after a tick so the synchroniser has settled by the next
		for (int i = 0; i < 11; i++) begin
			do @(posedge ref_clk); while (baud_tick !== 1'h1);
			rxd <= f[i];
		end
		do @(posedge ref_clk); while (baud_tick !== 1'h1);
	endtask : send_frame
	// mid-bit sampling from the falling start edge, twelve bit times
	task automatic capture(output logic [11:0] b);
		int n;
		n = 0;
		while (txd !== 1'h0 && n < 4000) begin
			@(posedge ref_clk);
			n++;
		end
		repeat (BIT_CLKS / 2) @(posedge ref_clk);
		for (int i = 0; i < 12; i++) begin
			b[i] = txd;
			if (i < 11) repeat (BIT_CLKS) @(posedge ref_clk);
		end
	endtask : capture
endmodule : serial_peer

// file: tb_serial_mode_ctrl.sv
`timescale 1ns/1ns
`include "serial_mode_cfg.svh"
// ==================================================
// bench for the mode control block
module tb_serial_mode_ctrl;
	logic        REF_CLK, RST_N, CLK_EN, AWVALID, WVALID, BREADY, ARVALID, RREADY;
	logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, TIMER_OUT, BAUD_TICK, IDLE_MODE;
	logic        RXD, CTS_N, SERIAL_CLOCK_PIN, TXD, RX_EVENT, TX_FIFO_INIT;
	logic [7:0]  AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA, v;
	logic [3:0]  WSTRB;
	logic [1:0]  BRESP, RRESP, last_resp;
	logic [2:0]  tcnt;
	logic [11:0] b;
	int          fail_count, check_count, ev_count, e0;

	// ==================================================
	// instances
	serial_mode_ctrl u_dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .CLK_EN(CLK_EN), .AWADDR(AWADDR),
		.AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
		.WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
		.ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
		.RREADY(RREADY), .TIMER_OUT(TIMER_OUT), .BAUD_TICK(BAUD_TICK),
		.SERIAL_CLOCK_PIN(SERIAL_CLOCK_PIN), .RXD(RXD), .CTS_N(CTS_N), .IDLE_MODE(IDLE_MODE),
		.TXD(TXD), .RX_EVENT(RX_EVENT), .TX_FIFO_INIT(TX_FIFO_INIT));
	serial_peer #(.BIT_CLKS(8)) u_peer (.ref_clk(REF_CLK), .baud_tick(BAUD_TICK), .txd(TXD),
		.rxd(RXD), .cts_n(CTS_N), .serial_clock_pin(SERIAL_CLOCK_PIN));

	// ==================================================
	// clock, bit tick every eight clocks, receive event counter
	initial begin
		REF_CLK = 1'h0;
		forever #50 REF_CLK = ~REF_CLK;
	end
	always @(posedge REF_CLK) begin
		tcnt <= tcnt + 3'h1;
		BAUD_TICK <= (tcnt == 3'h7);
		if (RX_EVENT === 1'h1) ev_count <= ev_count + 1;
	end

	// ==================================================
	// compare, bus tasks, verdict
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
		@(posedge REF_CLK);
		AWADDR <= a;
		WDATA <= d;
		WSTRB <= s;
		AWVALID <= 1'h1;
		WVALID <= 1'h1;
		BREADY <= 1'h1;
		// waits for the answer however long; only the watchdog ends a hang
		do begin
			@(posedge REF_CLK);
			if (AWVALID && AWREADY) AWVALID <= 1'h0;
			if (WVALID && WREADY) WVALID <= 1'h0;
		end while (!(BVALID === 1'h1));
		last_resp = BRESP;
		BREADY <= 1'h0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge REF_CLK);
		ARADDR <= a;
		ARVALID <= 1'h1;
		RREADY <= 1'h1;
		do begin
			@(posedge REF_CLK);
			if (ARVALID && ARREADY) ARVALID <= 1'h0;
		end while (!(RVALID === 1'h1));
		d = RDATA;
		last_resp = RRESP;
		RREADY <= 1'h0;
	endtask : rd
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	// hang guard, far beyond the roughly one thousand cycles the sequence needs
	initial begin
		repeat (30000) @(posedge REF_CLK);
		fail_count++;
		give_verdict();
	end

	// ==================================================
	// main sequence
	initial begin
		{RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, TIMER_OUT, IDLE_MODE, BAUD_TICK} = '0;
		{AWADDR, ARADDR, WDATA, tcnt} = '0;
		{fail_count, check_count, ev_count} = '0;
		WSTRB = 4'hF;
		CLK_EN = 1'h1;
		repeat (16) @(posedge REF_CLK);
		RST_N <= 1'h1;
		rd(`OFS_MODE0, v); chk("mode0 reset", v, 32'h0);
		rd(`OFS_MODE2, v); chk("mode2 reset", v, 32'h80);
		rd(`OFS_ENABLE, v); chk("enable reset", v, 32'h0);
		chk("fifo init reset", TX_FIFO_INIT, 32'h1);
		rd(8'h18, v); chk("unmapped read", last_resp, `RESP_SLVERR);
		wr(8'h1C, 32'h1); chk("unmapped write", last_resp, `RESP_SLVERR);
		wr(`OFS_MODE1, 32'h7E, 4'h0); rd(`OFS_MODE1, v); chk("no strobe", v, 32'h0);
		wr(`OFS_MODE1, 32'hFF); rd(`OFS_MODE1, v); chk("mode1 fields", v, 32'hFE);
		// channel enable, then idle with and without keep-running
		wr(`OFS_MODE1, 32'h0); wr(`OFS_ENABLE, 32'h1);
		@(posedge REF_CLK);
		chk("fifo init enabled", TX_FIFO_INIT, 32'h0);
		// clock enable low must hold the output through the idle request
		CLK_EN <= 1'h0;
		IDLE_MODE <= 1'h1;
		repeat (3) @(posedge REF_CLK);
		chk("enable low freezes", TX_FIFO_INIT, 32'h0);
		CLK_EN <= 1'h1;
		repeat (3) @(posedge REF_CLK);
		chk("idle stops", TX_FIFO_INIT, 32'h1);
		wr(`OFS_MODE1, 32'h80); @(posedge REF_CLK);
		chk("idle keeps running", TX_FIFO_INIT, 32'h0);
		IDLE_MODE <= 1'h0;
		// 9-bit frame, ninth bit 1, two stops, held off by clear-to-send
		u_peer.set_cts(1'h1);
		wr(`OFS_MODE0, 32'hCD); wr(`OFS_MODE2, 32'h10); wr(`OFS_MODE1, 32'h90);
		wr(`OFS_DATA, 32'hA5);
		repeat (40) @(posedge REF_CLK);
		chk("txd held", TXD, 32'h1);
		rd(`OFS_MODE2, v); chk("waiting status", v, 32'h10);
		u_peer.set_cts(1'h0);
		u_peer.capture(b); rd(`OFS_MODE2, v);
		chk("second stop running", v, 32'hB0);
		chk("frame two stops", b, {2'h3, 1'h1, 8'hA5, 1'h0});
		repeat (16) @(posedge REF_CLK);
		rd(`OFS_MODE2, v); chk("complete status", v, 32'h90);
		// one stop bit: line already idle where the second stop would be
		wr(`OFS_MODE2, 32'h0); wr(`OFS_DATA, 32'h3C);
		u_peer.capture(b); rd(`OFS_MODE2, v);
		chk("one stop done", v, 32'h80);
		chk("frame one stop", b, {2'h3, 1'h1, 8'h3C, 1'h0});
		// receive with wake-up filter, receive enabled last
		wr(`OFS_MODE1, 32'h80); wr(`OFS_MODE0, 32'h1D); wr(`OFS_MODE0, 32'h3D);
		e0 = ev_count;
		u_peer.send_frame(9'h03C); repeat (16) @(posedge REF_CLK);
		chk("filtered frame", ev_count, e0);
		u_peer.send_frame(9'h15A); repeat (16) @(posedge REF_CLK);
		chk("addressed frame", ev_count, e0 + 1);
		rd(`OFS_MODE2, v); chk("buffer full", v & 32'h40, 32'h40);
		rd(`OFS_MODE2, v); chk("full cleared", v & 32'h40, 32'h0);
		rd(`OFS_DATA, v); chk("rx data", v, 32'h15A);
		wr(`OFS_MODE0, 32'h0D); wr(`OFS_MODE0, 32'h2D);
		u_peer.send_frame(9'h0C3); repeat (16) @(posedge REF_CLK);
		chk("unfiltered frame", ev_count, e0 + 2);
		// two-write software reset, given twice since a frame is on the line
		wr(`OFS_MODE1, 32'h90); wr(`OFS_DATA, 32'h55); repeat (20) @(posedge REF_CLK);
		wr(`OFS_MODE2, 32'h2); wr(`OFS_MODE2, 32'h1);
		wr(`OFS_MODE2, 32'h2); wr(`OFS_MODE2, 32'h1); repeat (4) @(posedge REF_CLK);
		chk("line idle after reset", TXD, 32'h1);
		rd(`OFS_MODE0, v); chk("rx enable cleared", v, 32'h0D);
		rd(`OFS_MODE1, v); chk("tx enable cleared", v, 32'h80);
		rd(`OFS_MODE2, v); chk("flags reset", v, 32'h80);
		// reprogram after reset: i/o mode, msb first, transmit direction
		wr(`OFS_MODE0, 32'h0); wr(`OFS_MODE2, 32'h8); wr(`OFS_MODE1, 32'hD0);
		wr(`OFS_DATA, 32'h35); u_peer.capture(b);
		chk("io frame msb first", b, {4'hF, 8'hAC});
		give_verdict();
	end
endmodule : tb_serial_mode_ctrl
